// [design/drec_channel.sv]
/*
 * One channel of the reclocker edge control: rate selector, mute,
 * equalizer control and channel lamp decoding.
 * Assumes button and status inputs are synchronous to pclk; the
 * button is debounced here.
 */
`timescale 1ns/10ps
`include "drec_map.svh"
module drec_channel (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic rate_button,
   input wire logic remote_wr,
   input wire drec_pkg::drec_rate_t remote_rate,
   input wire logic mute_opt,
   input wire logic noeq_opt,
   input wire logic eq_valid,
   input wire logic lock,
   input wire drec_pkg::drec_det_t det_rate,
   input wire logic signed [7:0] rx_power_dbm,
   output drec_pkg::drec_rate_t rate_q,
   output logic out_mute,
   output logic eq_enable,
   output logic auto_detect_en,
   output logic reclock_en,
   output logic slew_hd,
   output drec_pkg::drec_lamp_t input_lamp,
   output drec_pkg::drec_lamp_t lock_lamp,
   output logic auto_lamp,
   output logic manual_lamp,
   output logic bypass_lamp,
   output logic other_lamp,
   output logic sd_rate_lamp,
   output logic hd_rate_lamp,
   output logic uhd_rate_lamp,
   output logic [4:0] power_bar
);
   import drec_pkg::*;

   localparam int DEB_CYC = `DREC_DEB_CYC;

   logic [10:0] deb_cnt_q;
   logic btn_q;
   logic press;

   // ----------------------------------------------------------------
   // Button debounce and press detect
   // ----------------------------------------------------------------
   // Contact bounce would skip entries in the cycle, so the level must
   // hold stable for the debounce time before it is believed
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         deb_cnt_q <= 11'h000;
         btn_q <= 1'b0;
      end
      else if (rate_button == btn_q)
         deb_cnt_q <= 11'h000;
      else if (deb_cnt_q == 11'(DEB_CYC - 1))
      begin
         deb_cnt_q <= 11'h000;
         btn_q <= rate_button;
      end
      else
         deb_cnt_q <= deb_cnt_q + 11'h001;
   end

   assign press = (rate_button == btn_q) ? 1'b0 :
                  (deb_cnt_q == 11'(DEB_CYC - 1)) & rate_button;

   // ----------------------------------------------------------------
   // Rate state
   // ----------------------------------------------------------------
   // A press wins over a remote write in the same cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rate_q <= DREC_AUTO;
      else if (press)
      begin
         case (rate_q)
            DREC_AUTO: rate_q <= DREC_BYPASS;
            DREC_BYPASS: rate_q <= DREC_SD;
            DREC_SD: rate_q <= DREC_HD;
            DREC_HD: rate_q <= DREC_3G;
            default: rate_q <= DREC_AUTO;
         endcase
      end
      else if (remote_wr)
         rate_q <= remote_rate;
   end

   // ----------------------------------------------------------------
   // Datapath controls
   // ----------------------------------------------------------------
   always_comb
   begin
      out_mute = mute_opt & (!eq_valid | !lock);
      eq_enable = !((rate_q == DREC_BYPASS) & noeq_opt);
      auto_detect_en = (rate_q == DREC_AUTO);
      reclock_en = (rate_q != DREC_BYPASS);
      // SD slew for a valid SD input in bypass or a detected SD rate in auto; fixed rates follow the set rate
      case (rate_q)
         DREC_BYPASS: slew_hd = !(eq_valid & (det_rate == DREC_DET_SD));
         DREC_SD: slew_hd = 1'b0;
         DREC_AUTO: slew_hd = (det_rate != DREC_DET_SD);
         default: slew_hd = 1'b1;
      endcase
   end

   // ----------------------------------------------------------------
   // Channel lamps
   // ----------------------------------------------------------------
   always_comb
   begin
      input_lamp = eq_valid ? DREC_GREEN : DREC_RED;
      if (rate_q == DREC_BYPASS)
         lock_lamp = DREC_OFF;
      else
         lock_lamp = lock ? DREC_GREEN : DREC_RED;
      auto_lamp = (rate_q == DREC_AUTO);
      manual_lamp = (rate_q != DREC_AUTO);
      bypass_lamp = (rate_q == DREC_BYPASS);
      other_lamp = 1'b0;
      sd_rate_lamp = (rate_q == DREC_SD) |
                     (auto_lamp & lock & (det_rate == DREC_DET_SD));
      hd_rate_lamp = (rate_q == DREC_HD) |
                     (auto_lamp & lock & (det_rate == DREC_DET_HD));
      uhd_rate_lamp = (rate_q == DREC_3G) |
                      (auto_lamp & lock & (det_rate == DREC_DET_3G));
      // Thermometer bar; bit 0 is the -6 dBm lamp
      power_bar[0] = rx_power_dbm > `DREC_THR_0;
      power_bar[1] = rx_power_dbm > `DREC_THR_1;
      power_bar[2] = rx_power_dbm > `DREC_THR_2;
      power_bar[3] = rx_power_dbm > `DREC_THR_3;
      power_bar[4] = rx_power_dbm > `DREC_THR_4;
   end
endmodule

// [design/drec_map.svh]
/*
 * Constants for the dual reclocker card-edge control block: register
 * offsets, field positions, reset values and timing counts.
 * Assumes inclusion by bare name from package and modules.
 */
`ifndef DREC_MAP_SVH
`define DREC_MAP_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define DREC_OFF_CTRL 12'h000
`define DREC_OFF_RATE_A 12'h004
`define DREC_OFF_RATE_B 12'h008
`define DREC_OFF_STAT_A 12'h00c
`define DREC_OFF_STAT_B 12'h010
`define DREC_OFF_CARD 12'h014

// ----------------------------------------------------------------
// Field positions of the remote channel control word
// ----------------------------------------------------------------
`define DREC_CTRL_MUTE_A 0
`define DREC_CTRL_NOEQ_A 1
`define DREC_CTRL_MUTE_B 2
`define DREC_CTRL_NOEQ_B 3
`define DREC_CTRL_RESET 4'h0

// ----------------------------------------------------------------
// Power bar thresholds in dBm, signed eight bits
// ----------------------------------------------------------------
`define DREC_THR_0 8'shfa
`define DREC_THR_1 8'shf7
`define DREC_THR_2 8'shf4
`define DREC_THR_3 8'shf1
`define DREC_THR_4 8'shee

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DREC_CLK_HZ 10000000
`define DREC_FLASH_MS 250
`define DREC_FLASH_CYC ((`DREC_CLK_HZ / 1000) * `DREC_FLASH_MS)
`define DREC_DEB_US 100
`define DREC_DEB_CYC ((`DREC_CLK_HZ / 1000000) * `DREC_DEB_US)

`endif

// [design/drec_pkg.sv]
/*
 * Types shared by the dual reclocker edge control files.
 * Assumes the constant header is on the include path.
 */
package drec_pkg;
   `include "drec_map.svh"

   // Rate setting, in button cycle order
   typedef enum logic [2:0] {
      DREC_AUTO,
      DREC_BYPASS,
      DREC_SD,
      DREC_HD,
      DREC_3G
   } drec_rate_t;

   // Rate the reclocker reports it is locked to
   typedef enum logic [1:0] {
      DREC_DET_NONE,
      DREC_DET_SD,
      DREC_DET_HD,
      DREC_DET_3G
   } drec_det_t;

   // Two-bit lamp colour
   typedef enum logic [1:0] {
      DREC_OFF,
      DREC_GREEN,
      DREC_YELLOW,
      DREC_RED
   } drec_lamp_t;

   // Processor and card state, as given by the board processor
   typedef enum logic [2:0] {
      DREC_ST_NOPWR,
      DREC_ST_PWRON,
      DREC_ST_CPUBOOT,
      DREC_ST_BOOTLOAD,
      DREC_ST_RUN
   } drec_card_t;
endpackage

// [design/drec_top.sv]
/*
 * Top of the dual reclocker card-edge control: configuration source
 * arbitration, APB register file, power lamp and two channels.
 * Assumes jumpers, buttons and status inputs are synchronous to pclk
 * and an APB master on the same clock.
 */
// Contract
// - Remote position takes all configuration remotely, jumpers ignored.
// - Remote position still accepts local rate button presses.
// - Local position (default) rejects remote configuration writes.
// - Local position still reports status and configuration remotely.
// - Loss-of-signal jumper used only in local position.
// - Mute option mutes outputs on no valid input or no lock.
// - No-mute option, the default, keeps outputs active.
// - Bypass with no-equalizer option disables the equalizer.
// - Each press advances auto, bypass, SD_RATE_SETTING, 1.5G, 3G cyclically.
// - Auto mode detects input rate and locks to any supported rate.
// - Bypass passes input unreclocked; HD slew unless valid SD.
// - Fixed rate reclocks only at that rate, detection disabled.
// - Channel B has its own button and options, same choices.
// - Power lamp green, flashing green, yellow, red or off by state.
// - Input lamp green on valid input, red otherwise.
// - Lock lamp green locked, red unlocked, off in bypass.
// - Auto, manual and bypass lamps per mode; spare lamp never lit.
// - Rate lamp lit when that rate fixed or auto-locked to it.
// - Transmitter variant fiber lamp green healthy, red on fault.
// - Each channel drives five lamps for received optical power.
// - Power bar thermometer at -6,-9,-12,-15,-18 dBm thresholds.
`timescale 1ns/10ps
`include "drec_map.svh"
module drec_top #(
   parameter int FLASH_CYC = `DREC_FLASH_CYC,
   parameter bit TX_VARIANT = 1'b1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic config_source_jumper,
   input wire logic loss_action_jumper_a,
   input wire logic eq_bypass_jumper_a,
   input wire logic rate_button_a,
   input wire logic loss_action_jumper_b,
   input wire logic eq_bypass_jumper_b,
   input wire logic rate_button_b,
   input wire logic boot_service_button,
   input wire drec_pkg::drec_card_t card_state,
   input wire logic card_fault,
   input wire logic eq_valid_a,
   input wire logic lock_a,
   input wire drec_pkg::drec_det_t det_rate_a,
   input wire logic signed [7:0] rx_power_a,
   input wire logic eq_valid_b,
   input wire logic lock_b,
   input wire drec_pkg::drec_det_t det_rate_b,
   input wire logic signed [7:0] rx_power_b,
   input wire logic tx_fault,
   output logic boot_request,
   output drec_pkg::drec_lamp_t power_state_lamp,
   output drec_pkg::drec_lamp_t fiber_tx_lamp,
   output logic mute_a,
   output logic eq_enable_a,
   output logic auto_detect_a,
   output logic reclock_a,
   output logic slew_hd_a,
   output drec_pkg::drec_lamp_t input_lamp_a,
   output drec_pkg::drec_lamp_t lock_lamp_a,
   output logic [5:0] mode_lamps_a,
   output logic [4:0] power_bar_a,
   output logic mute_b,
   output logic eq_enable_b,
   output logic auto_detect_b,
   output logic reclock_b,
   output logic slew_hd_b,
   output drec_pkg::drec_lamp_t input_lamp_b,
   output drec_pkg::drec_lamp_t lock_lamp_b,
   output logic [5:0] mode_lamps_b,
   output logic [4:0] power_bar_b
);
   import drec_pkg::*;

   logic remote;
   logic [3:0] ctrl_q;
   logic mute_opt_a, mute_opt_b, noeq_opt_a, noeq_opt_b;
   logic wr_en, rd_en;
   logic wr_rate_a, wr_rate_b;
   drec_rate_t rate_a, rate_b, wr_rate;
   logic [21:0] flash_cnt_q;
   logic flash_q;

   // Jumper high means remote; low, the default, is local
   assign remote = config_source_jumper;

   // ----------------------------------------------------------------
   // APB slave, zero wait states
   // ----------------------------------------------------------------
   assign pready = 1'b1;
   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & !penable & !pwrite;

   // Write decoding shared by the register file and rate ports
   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      hit = (a == off);
   endfunction

   function automatic logic mapped(input logic [11:0] a);
      mapped = hit(a, `DREC_OFF_CTRL) | hit(a, `DREC_OFF_RATE_A) |
               hit(a, `DREC_OFF_RATE_B) | hit(a, `DREC_OFF_STAT_A) |
               hit(a, `DREC_OFF_STAT_B) | hit(a, `DREC_OFF_CARD);
   endfunction

   // Error on unmapped address, or on a configuration write in local
   // position, so software learns its change was refused
   assign pslverr = psel & penable &
                    (!mapped(paddr) | (pwrite & !remote & hit(paddr, `DREC_OFF_CTRL)) |
                     (pwrite & !remote & (hit(paddr, `DREC_OFF_RATE_A) |
                                          hit(paddr, `DREC_OFF_RATE_B))));

   // Rates above the cycle length fall back to auto rather than an
   // unreachable state
   assign wr_rate = (pwdata[2:0] > 3'h4) ? DREC_AUTO : drec_rate_t'(pwdata[2:0]);
   assign wr_rate_a = wr_en & remote & pstrb[0] & hit(paddr, `DREC_OFF_RATE_A);
   assign wr_rate_b = wr_en & remote & pstrb[0] & hit(paddr, `DREC_OFF_RATE_B);

   // Remote option word; only stored in remote position
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl_q <= `DREC_CTRL_RESET;
      else if (wr_en & remote & pstrb[0] & hit(paddr, `DREC_OFF_CTRL))
         ctrl_q <= pwdata[3:0];
   end

   // Option source: jumpers in local, remote word in remote
   always_comb
   begin
      if (remote)
      begin
         mute_opt_a = ctrl_q[`DREC_CTRL_MUTE_A];
         noeq_opt_a = ctrl_q[`DREC_CTRL_NOEQ_A];
         mute_opt_b = ctrl_q[`DREC_CTRL_MUTE_B];
         noeq_opt_b = ctrl_q[`DREC_CTRL_NOEQ_B];
      end
      else
      begin
         mute_opt_a = loss_action_jumper_a;
         noeq_opt_a = eq_bypass_jumper_a;
         mute_opt_b = loss_action_jumper_b;
         noeq_opt_b = eq_bypass_jumper_b;
      end
   end

   // Read data registered in setup; reads work in both positions
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (rd_en)
      begin
         case (paddr)
            `DREC_OFF_CTRL: prdata <= {27'h0, remote, mute_opt_b ? 1'b1 : 1'b0,
                                       noeq_opt_a, mute_opt_a, noeq_opt_b} &
                                      32'h0000_001f;
            `DREC_OFF_RATE_A: prdata <= {29'h0, rate_a};
            `DREC_OFF_RATE_B: prdata <= {29'h0, rate_b};
            `DREC_OFF_STAT_A: prdata <= {14'h0, rx_power_a, power_bar_a,
                                         det_rate_a, lock_a, eq_valid_a, mute_a};
            `DREC_OFF_STAT_B: prdata <= {14'h0, rx_power_b, power_bar_b,
                                         det_rate_b, lock_b, eq_valid_b, mute_b};
            `DREC_OFF_CARD: prdata <= {27'h0, tx_fault, card_fault, card_state};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Power lamp and flash divider
   // ----------------------------------------------------------------
   // Flash toggles at a fixed rate so the bootloader state is visible
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flash_cnt_q <= 22'h000000;
         flash_q <= 1'b0;
      end
      else if (flash_cnt_q == 22'(FLASH_CYC - 1))
      begin
         flash_cnt_q <= 22'h000000;
         flash_q <= !flash_q;
      end
      else
         flash_cnt_q <= flash_cnt_q + 22'h000001;
   end

   always_comb
   begin
      if (card_fault)
         power_state_lamp = DREC_RED;
      else
      begin
         case (card_state)
            DREC_ST_NOPWR: power_state_lamp = DREC_OFF;
            DREC_ST_PWRON: power_state_lamp = DREC_RED;
            DREC_ST_CPUBOOT: power_state_lamp = DREC_YELLOW;
            DREC_ST_BOOTLOAD: power_state_lamp = flash_q ? DREC_GREEN : DREC_OFF;
            DREC_ST_RUN: power_state_lamp = DREC_GREEN;
            default: power_state_lamp = DREC_RED;
         endcase
      end
      // Receive-only variant has no transmitter lamp
      if (TX_VARIANT)
         fiber_tx_lamp = tx_fault ? DREC_RED : DREC_GREEN;
      else
         fiber_tx_lamp = DREC_OFF;
   end

   // Bootload button passes straight to the board processor
   assign boot_request = boot_service_button;

   // ----------------------------------------------------------------
   // Channels
   // ----------------------------------------------------------------
   // Each instance sees only its own status inputs
   drec_channel u_chan_a (
      .pclk(pclk),
      .presetn(presetn),
      .rate_button(rate_button_a),
      .remote_wr(wr_rate_a),
      .remote_rate(wr_rate),
      .mute_opt(mute_opt_a),
      .noeq_opt(noeq_opt_a),
      .eq_valid(eq_valid_a),
      .lock(lock_a),
      .det_rate(det_rate_a),
      .rx_power_dbm(rx_power_a),
      .rate_q(rate_a),
      .out_mute(mute_a),
      .eq_enable(eq_enable_a),
      .auto_detect_en(auto_detect_a),
      .reclock_en(reclock_a),
      .slew_hd(slew_hd_a),
      .input_lamp(input_lamp_a),
      .lock_lamp(lock_lamp_a),
      .auto_lamp(mode_lamps_a[0]),
      .manual_lamp(mode_lamps_a[1]),
      .bypass_lamp(mode_lamps_a[2]),
      .other_lamp(),
      .sd_rate_lamp(mode_lamps_a[3]),
      .hd_rate_lamp(mode_lamps_a[4]),
      .uhd_rate_lamp(mode_lamps_a[5]),
      .power_bar(power_bar_a)
   );

   drec_channel u_chan_b (
      .pclk(pclk),
      .presetn(presetn),
      .rate_button(rate_button_b),
      .remote_wr(wr_rate_b),
      .remote_rate(wr_rate),
      .mute_opt(mute_opt_b),
      .noeq_opt(noeq_opt_b),
      .eq_valid(eq_valid_b),
      .lock(lock_b),
      .det_rate(det_rate_b),
      .rx_power_dbm(rx_power_b),
      .rate_q(rate_b),
      .out_mute(mute_b),
      .eq_enable(eq_enable_b),
      .auto_detect_en(auto_detect_b),
      .reclock_en(reclock_b),
      .slew_hd(slew_hd_b),
      .input_lamp(input_lamp_b),
      .lock_lamp(lock_lamp_b),
      .auto_lamp(mode_lamps_b[0]),
      .manual_lamp(mode_lamps_b[1]),
      .bypass_lamp(mode_lamps_b[2]),
      .other_lamp(),
      .sd_rate_lamp(mode_lamps_b[3]),
      .hd_rate_lamp(mode_lamps_b[4]),
      .uhd_rate_lamp(mode_lamps_b[5]),
      .power_bar(power_bar_b)
   );
endmodule

// [testbench/drec_checker.sv]
/*
 * Port-level checker for the reclocker edge control top.
 * Assumes it is bound to drec_top and watches channel A and card lamps.
 */
`timescale 1ns/10ps
module drec_checker
   import drec_pkg::*;
#(
   parameter int FLASH_CYC = 4,
   parameter bit TX_VARIANT = 1'b1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic pslverr,
   input wire logic config_source_jumper,
   input wire logic loss_action_jumper_a,
   input wire logic eq_bypass_jumper_a,
   input wire logic eq_valid_a,
   input wire logic card_fault,
   input wire logic tx_fault,
   input wire drec_lamp_t power_state_lamp,
   input wire drec_lamp_t fiber_tx_lamp,
   input wire logic mute_a,
   input wire logic eq_enable_a,
   input wire logic auto_detect_a,
   input wire drec_lamp_t input_lamp_a,
   input wire drec_lamp_t lock_lamp_a,
   input wire logic [5:0] mode_lamps_a,
   input wire logic signed [7:0] rx_power_a,
   input wire logic [4:0] power_bar_a
);
   // ----------------------------------------
   // Relations between inputs and lamps
   // ----------------------------------------
   // Lamps are combinational, so each edge compares settled values
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_mute_on_loss: assert property (!config_source_jumper && loss_action_jumper_a && !eq_valid_a
      |-> mute_a) else $error("mute missing on loss");
   a_no_mute_dflt: assert property (!config_source_jumper && !loss_action_jumper_a
      |-> !mute_a) else $error("mute without option");
   a_input_lamp: assert property (input_lamp_a == (eq_valid_a ? DREC_GREEN : DREC_RED))
      else $error("input lamp colour");
   a_bypass_lamps: assert property (mode_lamps_a[2] |-> mode_lamps_a[1] && !mode_lamps_a[0]
      && lock_lamp_a == DREC_OFF) else $error("bypass lamps");
   a_eq_off_bypass: assert property (!config_source_jumper |->
      eq_enable_a == !(mode_lamps_a[2] && eq_bypass_jumper_a)) else $error("eq enable");
   a_auto_mode_lamp: assert property (auto_detect_a == mode_lamps_a[0]
      && mode_lamps_a[0] != mode_lamps_a[1]) else $error("auto lamp");
   a_fault_red: assert property (card_fault |-> power_state_lamp == DREC_RED)
      else $error("fault not red");
   a_fiber_color: assert property (fiber_tx_lamp == (!TX_VARIANT ? DREC_OFF :
      tx_fault ? DREC_RED : DREC_GREEN)) else $error("fiber lamp");
   a_bar_full: assert property (rx_power_a > -8'sd6 |-> power_bar_a == 5'h1f)
      else $error("bar not full");
   a_bar_empty: assert property (rx_power_a < -8'sd18 |-> power_bar_a == 5'h00)
      else $error("bar not empty");
   // A refused rate write must leave the mode lamps untouched next cycle
   a_local_refuse: assert property (psel && penable && pwrite && !config_source_jumper
      && paddr == 12'h004 |-> pslverr ##1 $stable(mode_lamps_a)) else $error("write taken");
   c_bypass: cover property (mode_lamps_a[2]);
   c_mute: cover property (mute_a);
   c_refused: cover property (pslverr);
endmodule

// [testbench/tb_dual_reclocker_edge_control.sv]
/*
 * Self-checking bench for the reclocker edge control top: APB tasks,
 * button presses and lamp comparisons.
 * Assumes drec_top with a short flash period and the checker beside it.
 */
`timescale 1ns/10ps
`include "drec_map.svh"
module tb_dual_reclocker_edge_control;
   import drec_pkg::*;
   logic pclk, pready, pslverr, boot_request;
   logic presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] pstrb = 4'hf;
   logic config_source_jumper = 0, loss_action_jumper_a = 0, eq_bypass_jumper_a = 1;
   logic loss_action_jumper_b = 1, eq_bypass_jumper_b = 0, boot_service_button = 0;
   logic rate_button_a = 0, rate_button_b = 0, card_fault = 0, tx_fault = 0, er;
   logic eq_valid_a = 1, lock_a = 0, eq_valid_b = 1, lock_b = 1;
   drec_card_t card_state = DREC_ST_RUN;
   drec_det_t det_rate_a = DREC_DET_NONE, det_rate_b = DREC_DET_NONE;
   logic signed [7:0] rx_power_a = -8'sd20, rx_power_b = -8'sd20;
   drec_lamp_t power_state_lamp, fiber_tx_lamp, input_lamp_a, lock_lamp_a;
   drec_lamp_t input_lamp_b, lock_lamp_b;
   logic mute_a, eq_enable_a, auto_detect_a, reclock_a, slew_hd_a;
   logic mute_b, eq_enable_b, auto_detect_b, reclock_b, slew_hd_b;
   logic [5:0] mode_lamps_a, mode_lamps_b;
   logic [4:0] power_bar_a, power_bar_b;
   int num_errors = 0, check_count = 0;
   logic [5:0] lamps [5] = '{6'h01, 6'h06, 6'h0a, 6'h12, 6'h22};
   logic signed [7:0] pw [6] = '{-8'sd3, -8'sd7, -8'sd10, -8'sd13, -8'sd16, -8'sd20};
   logic [4:0] bar [6] = '{5'h1f, 5'h1e, 5'h1c, 5'h18, 5'h10, 5'h00};
   drec_card_t cs [4] = '{DREC_ST_NOPWR, DREC_ST_PWRON, DREC_ST_CPUBOOT, DREC_ST_RUN};
   drec_lamp_t pl [4] = '{DREC_OFF, DREC_RED, DREC_YELLOW, DREC_GREEN};

   drec_top #(.FLASH_CYC(4), .TX_VARIANT(1'b1)) DUT (.*);

   // ----------------------------------------
   // Clock, tasks
   // ----------------------------------------
   initial
   begin
      pclk = 0;
      forever #50 pclk = ~pclk;
   end

   task automatic print_verdict;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      for (n = 0; n < 16 && pready !== 1'b1; n++)
         @(posedge pclk);
      if (n == 16)
      begin
         num_errors++;
         print_verdict();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Returns on a rising edge; outputs read there were settled a cycle ago
   task automatic settle;
      repeat (2) @(posedge pclk);
   endtask

   // Held past the 1000-cycle debounce both ways
   task automatic press(input bit b);
      @(posedge pclk);
      if (b)
         rate_button_b <= 1'b1;
      else
         rate_button_a <= 1'b1;
      repeat (1005) @(posedge pclk);
      rate_button_a <= 1'b0;
      rate_button_b <= 1'b0;
      repeat (1005) @(posedge pclk);
   endtask

   initial
   begin
      repeat (50000) @(posedge pclk);
      num_errors++;
      print_verdict();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      int i, k, g;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      settle();
      chk(mode_lamps_a, 6'h01);
      apb(0, `DREC_OFF_CARD, 0);
      chk(rd, 32'h4);
      $display("test reset done");
      for (i = 1; i <= 5; i++)
      begin
         press(0);
         k = i % 5;
         chk(mode_lamps_a, lamps[k]);
         chk(eq_enable_a, k != 1);
         chk(lock_lamp_a, k == 1 ? DREC_OFF : DREC_RED);
         chk(auto_detect_a, k == 0);
         chk(reclock_a, k != 1);
         chk(slew_hd_a, k != 2);
         chk(mode_lamps_b, 6'h01);
      end
      press(1);
      chk(mode_lamps_b, 6'h06);
      chk({eq_enable_b, reclock_b, auto_detect_b, slew_hd_b}, 4'b1001);
      chk(lock_lamp_b, DREC_OFF);
      $display("test buttons done");
      apb(1, `DREC_OFF_RATE_A, 32'h3);
      chk(er, 1'b1);
      settle();
      chk(mode_lamps_a, 6'h01);
      apb(0, 12'h020, 0);
      chk(er, 1'b1);
      chk(rd, 32'h0);
      $display("test local done");
      @(posedge pclk);
      config_source_jumper <= 1'b1;
      eq_valid_a <= 1'b0;
      apb(1, `DREC_OFF_RATE_A, 32'h3);
      chk(er, 1'b0);
      settle();
      chk(mode_lamps_a, 6'h12);
      press(0);
      chk(mode_lamps_a, 6'h22);
      apb(1, `DREC_OFF_CTRL, 32'h1);
      settle();
      chk(mute_a, 1'b1);
      apb(0, `DREC_OFF_CTRL, 0);
      chk(rd, 32'h12);
      apb(1, `DREC_OFF_CTRL, 32'h0);
      loss_action_jumper_a <= 1'b1;
      settle();
      chk(mute_a, 1'b0);
      apb(1, `DREC_OFF_RATE_A, 32'h0);
      config_source_jumper <= 1'b0;
      settle();
      chk(mute_a, 1'b1);
      chk(mute_b, 1'b0);
      eq_valid_a <= 1'b1;
      settle();
      chk(mute_a, 1'b1);
      loss_action_jumper_a <= 1'b0;
      settle();
      chk(mute_a, 1'b0);
      $display("test remote and mute done");
      lock_a <= 1'b1;
      det_rate_a <= DREC_DET_HD;
      settle();
      chk(mode_lamps_a, 6'h11);
      chk(lock_lamp_a, DREC_GREEN);
      chk(input_lamp_b, DREC_GREEN);
      for (i = 0; i < 6; i++)
      begin
         rx_power_a <= pw[i];
         settle();
         chk(power_bar_a, bar[i]);
         chk(power_bar_b, 5'h00);
      end
      for (i = 0; i < 4; i++)
      begin
         card_state <= cs[i];
         settle();
         chk(power_state_lamp, pl[i]);
      end
      card_fault <= 1'b1;
      tx_fault <= 1'b1;
      boot_service_button <= 1'b1;
      settle();
      chk(power_state_lamp, DREC_RED);
      chk(fiber_tx_lamp, DREC_RED);
      chk(boot_request, 1'b1);
      card_fault <= 1'b0;
      tx_fault <= 1'b0;
      card_state <= DREC_ST_BOOTLOAD;
      settle();
      g = 0;
      for (i = 0; i < 8; i++)
      begin
         @(posedge pclk);
         g += (power_state_lamp === DREC_GREEN);
      end
      chk(g > 0 && g < 8, 1'b1);
      chk(fiber_tx_lamp, DREC_GREEN);
      $display("test lamps done");
      print_verdict();
   end
endmodule

bind drec_top drec_checker #(.FLASH_CYC(FLASH_CYC), .TX_VARIANT(TX_VARIANT)) u_chk (.*);
